// >>> core/adcseq_clkdiv.sv
/*
 converter clock divider: one-cycle tick every 2^sel system clocks.
 assumes select is steady while a conversion runs.
*/
`include "adcseq_params.svh"
`default_nettype none
module adcseq_clkdiv
  import adcseq_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_run,
  input  wire logic [2:0] i_sel,
  output logic            o_tick
);
  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       tick_now;
  logic [6:0] lim;

  // ==========================================================
  // divider
  // tick is combinational: a registered tick would stretch the first
  // converter clock of every sample phase by one system clock
  always_comb begin
    lim      = 7'((8'h01 << i_sel) - 8'h01);
    nxt_cnt  = cnt_ff;
    tick_now = 1'b0;
    if (!i_run) begin
      nxt_cnt = 7'h00;
    end else if (cnt_ff >= lim) begin
      nxt_cnt  = 7'h00;
      tick_now = 1'b1;
    end else begin
      nxt_cnt = 7'(cnt_ff + 7'h01);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      cnt_ff <= 7'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign o_tick = tick_now;
endmodule
`default_nettype wire

// >>> core/adcseq_params.svh
/*
 constants for the conversion sequencer: register offsets, field positions,
 reset values and timing counts. assumes inclusion by bare name.
*/
`ifndef ADCSEQ_PARAMS_SVH
`define ADCSEQ_PARAMS_SVH
// ==========================================================
// register offsets (byte addresses on the plain port)
`define ADCSEQ_OFF_CTRL0     8'h00
`define ADCSEQ_OFF_CTRL1     8'h01
`define ADCSEQ_OFF_RES_HI    8'h02
`define ADCSEQ_OFF_RES_LO    8'h03
`define ADCSEQ_OFF_IRQ       8'h04
`define ADCSEQ_OFF_CAL_HI    8'h05
`define ADCSEQ_OFF_CAL_LO    8'h06
`define ADCSEQ_OFF_OPTMAP    8'h07
`define ADCSEQ_OFF_TBL_ADR   8'h08
`define ADCSEQ_OFF_TBL_DAT   8'h09
// ==========================================================
// control 0 fields
`define ADCSEQ_C0_START      7
`define ADCSEQ_C0_BUSY       6
`define ADCSEQ_C0_EN         5
`define ADCSEQ_C0_FMT        4
`define ADCSEQ_C0_CHAN_HI    3
// control 1 fields
`define ADCSEQ_C1_SRC_HI     7
`define ADCSEQ_C1_SRC_LO     5
`define ADCSEQ_C1_REF_HI     4
`define ADCSEQ_C1_REF_LO     3
`define ADCSEQ_C1_CLK_HI     2
// irq register fields
`define ADCSEQ_IRQ_FLAG      0
`define ADCSEQ_IRQ_EN        1
`define ADCSEQ_IRQ_GEN       2
// ==========================================================
// reset values and source codes
`define ADCSEQ_RST_CTRL0     8'h00
`define ADCSEQ_RST_CTRL1     8'h00
`define ADCSEQ_SRC_FORBID    3'h7
`define ADCSEQ_SRC_TEMP      3'h2
// ==========================================================
// timing in converter clocks
`define ADCSEQ_SAMPLE_CLKS   6'h04
`define ADCSEQ_SAMPLE_TS     6'h2e
`define ADCSEQ_CONV_CLKS     6'h0c
// ==========================================================
// calibration table window and full-scale code mask
`define ADCSEQ_TBL_T2        12'hff5
`define ADCSEQ_TBL_A2_HI     12'hff6
`define ADCSEQ_TBL_A2_LO     12'hff7
`define ADCSEQ_CODE_FULL     12'hfff
`endif

// >>> core/adcseq_pkg.sv
/*
 types shared by the conversion sequencer files.
 assumes the params header sits beside it.
*/
`default_nettype none
package adcseq_pkg;
  typedef enum logic [1:0] {
    ADCSEQ_IDLE,
    ADCSEQ_HOLD,
    ADCSEQ_SAMPLE,
    ADCSEQ_CONVERT
  } adcseq_state_t;
endpackage
`default_nettype wire

// >>> core/adcseq_top.sv
/*
 conversion sequencer: control registers, start handshake, sample and
 convert sequencing, result formatting, interrupt request and the
 temperature calibration constants.
 assumes a same-clock register master; the analog converter answers with
 a 12-bit code on i_conv_code sampled at the end of the conversion phase.
*/
// Decided for this implementation: the plain strobed port and the placing of the registers.
`include "adcseq_params.svh"
`default_nettype none
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter logic [11:0] CAL1_CODE = 12'h0800, // arbitrary factory value
  parameter logic [7:0]  CAL2_TEMP = 8'h7d,    // arbitrary factory value
  parameter logic [11:0] CAL2_CODE = 12'h0600  // arbitrary factory value
)(
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [11:0] i_conv_code,
  output logic      [7:0]  o_rdata,
  output logic             o_irq,
  output logic             o_conv_power,
  output logic             o_conv_reset,
  output logic             o_sampling,
  output logic      [2:0]  o_input_source_select,
  output logic      [3:0]  o_external_channel_select,
  output logic      [1:0]  o_ref_route
);
  // ==========================================================
  // functions
  function automatic logic [1:0] ref_decode(input logic [1:0] sel);
    // 0 pin or regulator, 1 converter supply, 2 sensor reference
    case (sel)
      2'h0:    ref_decode = 2'h0;
      2'h2:    ref_decode = 2'h2;
      default: ref_decode = 2'h1;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // state
  adcseq_state_t state_ff, nxt_state;
  logic        start_ff, nxt_start;
  logic        enable_ff, nxt_enable;
  logic        fmt_ff, nxt_fmt;
  logic [3:0]  chan_ff, nxt_chan;
  logic [2:0]  src_ff, nxt_src;
  logic [1:0]  refsel_ff, nxt_refsel;
  logic [2:0]  clksel_ff, nxt_clksel;
  logic        flag_ff, nxt_flag;
  logic        irq_en_ff, nxt_irq_en;
  logic        gen_ff, nxt_gen;
  logic        optmap_ff, nxt_optmap;
  logic [11:0] tbl_adr_ff, nxt_tbl_adr;
  logic [11:0] result_ff, nxt_result;
  logic [5:0]  cnt_ff, nxt_cnt;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        irq_ff, nxt_irq;
  logic        power_ff, nxt_power;
  logic        creset_ff, nxt_creset;
  logic        samp_ff, nxt_samp;
  logic [2:0]  src_o_ff, nxt_src_o;
  logic [3:0]  chan_o_ff, nxt_chan_o;
  logic [1:0]  ref_o_ff, nxt_ref_o;
  logic        tick;
  logic        conv_done;
  logic [15:0] res_fmt;
  logic [7:0]  tbl_data;

  adcseq_clkdiv u_div (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .i_run      (state_ff == ADCSEQ_SAMPLE || state_ff == ADCSEQ_CONVERT),
    .i_sel      (clksel_ff),
    .o_tick     (tick)
  );
  // last convert tick of a live conversion; an abort must not raise the flag
  assign conv_done = (state_ff == ADCSEQ_CONVERT) && tick && (cnt_ff == 6'h01) &&
                     enable_ff && !start_ff;

  // ==========================================================
  // result format and calibration table
  always_comb begin
    // fmt 0: left aligned, fmt 1: right aligned
    if (fmt_ff) begin
      res_fmt = {4'h0, result_ff};
    end else begin
      res_fmt = {result_ff, 4'h0};
    end
    tbl_data = 8'h00;
    if (optmap_ff) begin
      case (tbl_adr_ff)
        `ADCSEQ_TBL_T2:    tbl_data = CAL2_TEMP;
        `ADCSEQ_TBL_A2_HI: tbl_data = CAL2_CODE[11:4];
        `ADCSEQ_TBL_A2_LO: tbl_data = {4'h0, CAL2_CODE[3:0]};
        default:           tbl_data = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // register writes
  always_comb begin
    nxt_start   = start_ff;
    nxt_enable  = enable_ff;
    nxt_fmt     = fmt_ff;
    nxt_chan    = chan_ff;
    nxt_src     = src_ff;
    nxt_refsel  = refsel_ff;
    nxt_clksel  = clksel_ff;
    nxt_irq_en  = irq_en_ff;
    nxt_gen     = gen_ff;
    nxt_optmap  = optmap_ff;
    nxt_tbl_adr = tbl_adr_ff;
    nxt_flag    = flag_ff;
    if (i_wr) begin
      if (hit(i_addr, `ADCSEQ_OFF_CTRL0)) begin
        nxt_start  = i_wdata[`ADCSEQ_C0_START];
        nxt_enable = i_wdata[`ADCSEQ_C0_EN];
        nxt_fmt    = i_wdata[`ADCSEQ_C0_FMT];
        nxt_chan   = i_wdata[`ADCSEQ_C0_CHAN_HI:0];
      end
      if (hit(i_addr, `ADCSEQ_OFF_CTRL1)) begin
        // keep old source when the forbidden code is written
        if (i_wdata[`ADCSEQ_C1_SRC_HI:`ADCSEQ_C1_SRC_LO] != `ADCSEQ_SRC_FORBID) begin
          nxt_src = i_wdata[`ADCSEQ_C1_SRC_HI:`ADCSEQ_C1_SRC_LO];
        end
        nxt_refsel = i_wdata[`ADCSEQ_C1_REF_HI:`ADCSEQ_C1_REF_LO];
        nxt_clksel = i_wdata[`ADCSEQ_C1_CLK_HI:0];
      end
      if (hit(i_addr, `ADCSEQ_OFF_IRQ)) begin
        nxt_irq_en = i_wdata[`ADCSEQ_IRQ_EN];
        nxt_gen    = i_wdata[`ADCSEQ_IRQ_GEN];
        if (!i_wdata[`ADCSEQ_IRQ_FLAG]) begin
          nxt_flag = 1'b0;
        end
      end
      if (hit(i_addr, `ADCSEQ_OFF_OPTMAP)) begin
        nxt_optmap = i_wdata[0];
      end
      if (hit(i_addr, `ADCSEQ_OFF_TBL_ADR)) begin
        nxt_tbl_adr = {4'hf, i_wdata};
      end
    end
    // completion wins over a same-cycle clear
    if (conv_done) begin
      nxt_flag = 1'b1;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_result = result_ff;
    if (!enable_ff) begin
      nxt_state = ADCSEQ_IDLE;
      nxt_cnt   = 6'h00;
    end else if (start_ff) begin
      nxt_state = ADCSEQ_HOLD;
      nxt_cnt   = 6'h00;
    end else begin
      case (state_ff)
        ADCSEQ_IDLE: begin
          nxt_state = ADCSEQ_IDLE;
        end
        ADCSEQ_HOLD: begin
          nxt_state = ADCSEQ_SAMPLE;
          // temperature input needs the long sampling window
          nxt_cnt   = (src_ff == `ADCSEQ_SRC_TEMP) ? `ADCSEQ_SAMPLE_TS
                                                   : `ADCSEQ_SAMPLE_CLKS;
        end
        ADCSEQ_SAMPLE: begin
          if (tick) begin
            if (cnt_ff == 6'h01) begin
              nxt_state = ADCSEQ_CONVERT;
              nxt_cnt   = `ADCSEQ_CONV_CLKS;
            end else begin
              nxt_cnt = 6'(cnt_ff - 6'h01);
            end
          end
        end
        ADCSEQ_CONVERT: begin
          if (tick) begin
            if (cnt_ff == 6'h01) begin
              nxt_state  = ADCSEQ_IDLE;
              nxt_cnt    = 6'h00;
              // unsigned code masked to 12 bits; result held till next end
              nxt_result = i_conv_code & `ADCSEQ_CODE_FULL;
            end else begin
              nxt_cnt = 6'(cnt_ff - 6'h01);
            end
          end
        end
        default: begin
          nxt_state = ADCSEQ_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // read path and outputs
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `ADCSEQ_OFF_CTRL0:   nxt_rdata = {start_ff,
                                          state_ff != ADCSEQ_IDLE,
                                          enable_ff, fmt_ff, chan_ff};
        `ADCSEQ_OFF_CTRL1:   nxt_rdata = {src_ff, refsel_ff, clksel_ff};
        `ADCSEQ_OFF_RES_HI:  nxt_rdata = res_fmt[15:8];
        `ADCSEQ_OFF_RES_LO:  nxt_rdata = res_fmt[7:0];
        `ADCSEQ_OFF_IRQ:     nxt_rdata = {5'h00, gen_ff, irq_en_ff, flag_ff};
        `ADCSEQ_OFF_CAL_HI:  nxt_rdata = {4'h0, CAL1_CODE[11:8]};
        `ADCSEQ_OFF_CAL_LO:  nxt_rdata = CAL1_CODE[7:0];
        `ADCSEQ_OFF_OPTMAP:  nxt_rdata = {7'h00, optmap_ff};
        `ADCSEQ_OFF_TBL_ADR: nxt_rdata = tbl_adr_ff[7:0];
        `ADCSEQ_OFF_TBL_DAT: nxt_rdata = tbl_data;
        default:             nxt_rdata = 8'h00;
      endcase
    end
    nxt_irq    = nxt_flag & irq_en_ff & gen_ff;
    nxt_power  = enable_ff;
    nxt_creset = start_ff | ~enable_ff;
    // drop sampling as soon as start or disable lands: hold and sample never overlap
    nxt_samp   = (state_ff == ADCSEQ_SAMPLE) && !start_ff && enable_ff;
    nxt_src_o  = nxt_src;
    nxt_chan_o = nxt_chan;
    nxt_ref_o  = ref_decode(nxt_refsel);
  end

  // ==========================================================
  // register file flops
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      start_ff   <= 1'b0;
      enable_ff  <= 1'b0;
      fmt_ff     <= 1'b0;
      chan_ff    <= 4'h0;
      src_ff     <= 3'h0;
      refsel_ff  <= 2'h0;
      clksel_ff  <= 3'h0;
      flag_ff    <= 1'b0;
      irq_en_ff  <= 1'b0;
      gen_ff     <= 1'b0;
      optmap_ff  <= 1'b0;
      tbl_adr_ff <= 12'h000;
    end else begin
      start_ff   <= nxt_start;
      enable_ff  <= nxt_enable;
      fmt_ff     <= nxt_fmt;
      chan_ff    <= nxt_chan;
      src_ff     <= nxt_src;
      refsel_ff  <= nxt_refsel;
      clksel_ff  <= nxt_clksel;
      flag_ff    <= nxt_flag;
      irq_en_ff  <= nxt_irq_en;
      gen_ff     <= nxt_gen;
      optmap_ff  <= nxt_optmap;
      tbl_adr_ff <= nxt_tbl_adr;
    end
  end

  // ==========================================================
  // sequencer flops
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      state_ff   <= ADCSEQ_IDLE;
      result_ff  <= 12'h000;
      cnt_ff     <= 6'h00;
    end else begin
      state_ff   <= nxt_state;
      result_ff  <= nxt_result;
      cnt_ff     <= nxt_cnt;
    end
  end

  // ==========================================================
  // output flops
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      rdata_ff   <= 8'h00;
      irq_ff     <= 1'b0;
      power_ff   <= 1'b0;
      creset_ff  <= 1'b1;
      samp_ff    <= 1'b0;
      src_o_ff   <= 3'h0;
      chan_o_ff  <= 4'h0;
      ref_o_ff   <= 2'h0;
    end else begin
      rdata_ff   <= nxt_rdata;
      irq_ff     <= nxt_irq;
      power_ff   <= nxt_power;
      creset_ff  <= nxt_creset;
      samp_ff    <= nxt_samp;
      src_o_ff   <= nxt_src_o;
      chan_o_ff  <= nxt_chan_o;
      ref_o_ff   <= nxt_ref_o;
    end
  end

  assign o_rdata                   = rdata_ff;
  assign o_irq                     = irq_ff;
  assign o_conv_power              = power_ff;
  assign o_conv_reset              = creset_ff;
  assign o_sampling                = samp_ff;
  assign o_input_source_select     = src_o_ff;
  assign o_external_channel_select = chan_o_ff;
  assign o_ref_route               = ref_o_ff;
endmodule
`default_nettype wire

// >>> test/adcseq_asserts.sv
/*
 port checker for the conversion sequencer top.
 assumes it is bound to every adcseq_top; one clock, sync reset.
*/
`default_nettype none
module adcseq_asserts (
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       o_irq,
  input wire logic       o_conv_power,
  input wire logic       o_conv_reset,
  input wire logic       o_sampling,
  input wire logic [2:0] o_input_source_select,
  input wire logic [3:0] o_external_channel_select,
  input wire logic [1:0] o_ref_route
);
  // ==========================================
  // helpers: the clock field never leaves the block, so mirror it
  logic [2:0] sel_ff, nxt_sel;
  logic [5:0] len_ff, nxt_len;
  always_comb begin
    nxt_sel = (i_wr && i_addr == 8'h01) ? i_wdata[2:0] : sel_ff;
    nxt_len = o_sampling ? len_ff + 6'h01 : 6'h00;
  end
  always_ff @(posedge i_core_clk) begin
    sel_ff <= i_resetn ? nxt_sel : 3'h0;
    len_ff <= i_resetn ? nxt_len : 6'h00;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================
  // assertions
  a_rdata_quiet: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_off_resets: assert property (!o_conv_power |-> o_conv_reset)
    else $error("unpowered converter not held");
  a_enable_write: assert property (i_wr && i_addr == 8'h00 |-> ##2
    o_conv_power == $past(i_wdata[5], 2) && o_external_channel_select == $past(i_wdata[3:0], 2))
    else $error("enable or channel not taken");
  a_start_hold: assert property (i_wr && i_addr == 8'h00 |-> ##2
    o_conv_reset == ($past(i_wdata[7], 2) || !$past(i_wdata[5], 2)))
    else $error("start bit does not hold converter");
  a_hold_idle: assert property (o_conv_reset |-> !o_sampling)
    else $error("sampling while held");
  a_sample_len: assert property ($fell(o_sampling) && o_conv_power && sel_ff == 3'h0 |->
    len_ff == ((o_input_source_select == 3'h2) ? 6'h2e : 6'h04))
    else $error("sampling length wrong");
  a_irq_gate: assert property (i_wr && i_addr == 8'h04 && !(i_wdata[1] && i_wdata[2]) |->
    ##2 !o_irq)
    else $error("request without both enables");
  a_ref_decode: assert property (i_wr && i_addr == 8'h01 |-> ##2 o_ref_route ==
    (($past(i_wdata[4:3], 2) == 2'b10) ? 2'h2 : {1'b0, $past(i_wdata[3], 2)}))
    else $error("reference route wrong");
  a_src_legal: assert property (o_input_source_select != 3'h7)
    else $error("forbidden source code");
  a_src_write: assert property (i_wr && i_addr == 8'h01 && i_wdata[7:5] != 3'h7 |-> ##2
    o_input_source_select == $past(i_wdata[7:5], 2))
    else $error("source not taken");
  c_irq: cover property ($rose(o_irq));
  c_temp: cover property ($fell(o_sampling) && o_input_source_select == 3'h2);
  c_hold: cover property (o_conv_reset && o_conv_power);
endmodule
bind adcseq_top adcseq_asserts u_chk (.i_core_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_irq, .o_conv_power, .o_conv_reset, .o_sampling, .o_input_source_select,
  .o_external_channel_select, .o_ref_route);
`default_nettype wire

// >>> test/testbench.sv
/*
 self-checking bench for the conversion sequencer top.
 assumes the checker file binds itself; bench plays register master and converter.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] CAL1 = 12'h0a5c; // arbitrary
  localparam logic [7:0]  CALT = 8'h91;    // arbitrary
  localparam logic [11:0] CAL2 = 12'h03c7; // arbitrary
  logic        i_core_clk, i_resetn, i_wr, i_rd, o_irq, o_conv_power, o_conv_reset, o_sampling;
  logic [7:0]  i_addr, i_wdata, o_rdata;
  logic [11:0] i_conv_code;
  logic [2:0]  o_input_source_select;
  logic [3:0]  o_external_channel_select;
  logic [1:0]  o_ref_route;
  logic [31:0] seed = 32'h0000_e8d7;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cyc = 0;
  adcseq_top #(.CAL1_CODE(CAL1), .CAL2_TEMP(CALT), .CAL2_CODE(CAL2)) dut (.i_core_clk,
    .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_conv_code, .o_rdata, .o_irq, .o_conv_power,
    .o_conv_reset, .o_sampling, .o_input_source_select, .o_external_channel_select, .o_ref_route);
  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // high byte in [15:8], low byte in [7:0]
  function automatic logic [15:0] fmt_res(input logic f, input logic [11:0] c);
    return f ? {4'h0, c} : {c, 4'h0};
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  // ==========================================
  // tests
  initial begin
    logic [7:0]  d;
    logic [11:0] code;
    logic [15:0] e;
    logic [31:0] r;
    logic [3:0]  ch;
    logic [2:0]  s;
    logic        f;
    int          n;
    i_resetn = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_conv_code = 12'h000;
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    #1;
    chk(o_conv_reset, 1'b1);
    rd(8'h00, d);
    chk(d, 8'h00);
    rd(8'h05, d);
    chk(d, {4'h0, CAL1[11:8]});
    rd(8'h06, d);
    chk(d, CAL1[7:0]);
    wr(8'h08, 8'hf5);
    rd(8'h09, d);
    chk(d, 8'h00);
    wr(8'h07, 8'h01);
    rd(8'h09, d);
    chk(d, CALT);
    wr(8'h08, 8'hf6);
    rd(8'h09, d);
    chk(d, CAL2[11:4]);
    wr(8'h08, 8'hf7);
    rd(8'h09, d);
    chk(d, {4'h0, CAL2[3:0]});
    rd(8'h0a, d);
    chk(d, 8'h00);
    // source 111 must bounce while reference and clock still land
    wr(8'h01, 8'h29);
    wr(8'h01, 8'hf2);
    rd(8'h01, d);
    chk(d, 8'h32);
    $display("test registers done");
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      code = (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : r[11:0];
      s = (k == 2) ? 3'h2 : (r[14:12] == 3'h7) ? 3'h0 : r[14:12];
      f = r[15];
      ch = {s inside {[3'h1:3'h4]}, r[22:20]};
      i_conv_code <= code;
      wr(8'h00, {3'b001, f, ch});
      wr(8'h01, {s, r[17:16], (k < 4) ? 3'h0 : {1'b0, r[19:18]}});
      wr(8'h04, k[0] ? 8'h00 : 8'h06);
      wr(8'h00, {3'b101, f, ch});
      repeat (2 + r[25:24]) @(posedge i_core_clk);
      #1;
      chk(o_sampling, 1'b0);
      chk(o_conv_reset, 1'b1);
      wr(8'h00, {3'b001, f, ch});
      rd(8'h00, d);
      chk(d[6], 1'b1);
      n = 0;
      while (k[0] && d[6] === 1'b1 && n < 2000) begin
        rd(8'h00, d);
        n++;
      end
      while (!k[0] && o_irq !== 1'b1 && n < 2000) begin
        @(posedge i_core_clk);
        #1;
        n++;
      end
      chk(o_irq, !k[0]);
      rd(8'h00, d);
      chk(d[6], 1'b0);
      e = fmt_res(f, code);
      i_conv_code <= ~code;
      rd(8'h02, d);
      chk(d, e[15:8]);
      rd(8'h03, d);
      chk(d, e[7:0]);
      rd(8'h04, d);
      chk(d[0], 1'b1);
      wr(8'h04, 8'h06);
      rd(8'h04, d);
      chk(d, 8'h06);
      chk(o_irq, 1'b0);
    end
    $display("test conversions done");
    // abort in the convert phase: clearing enable must power down and drop the request
    wr(8'h01, 8'h03);
    wr(8'h00, 8'ha0);
    wr(8'h00, 8'h20);
    repeat (50) @(posedge i_core_clk);
    wr(8'h00, 8'h00);
    repeat (300) @(posedge i_core_clk);
    #1;
    chk(o_conv_power, 1'b0);
    chk(o_conv_reset, 1'b1);
    chk(o_irq, 1'b0);
    $display("test power down done");
    results();
  end
endmodule
`default_nettype wire
